/* File: include/vlp_defines.svh */
// Constants for the variable latency I/O port controller.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef VLP_DEFINES_SVH
`define VLP_DEFINES_SVH

`define VLP_NUM_CS          6
`define VLP_ADDR_W          26
`define VLP_DATA_W          32
`define VLP_LANES           4
`define VLP_SETUP_LAST      1
`define VLP_RDY_SAMPLE_CYC  1
`define VLP_RDY_OK_LAST     2'h2
`define VLP_MASK_ALL        4'hF
`define VLP_MASK_NONE       4'h0
`define VLP_MASK_HI16       4'hC
`define VLP_STEP32          26'h0000004
`define VLP_STEP16          26'h0000002
`define VLP_CS_IDLE         6'h3F
`define VLP_ADDR_RST        26'h0000000
`define VLP_DATA_RST        32'h00000000
`define VLP_LO16            32'h0000FFFF
`define VLP_BEATS_RST       8'h00

`endif

/* File: include/vlp_pkg.sv */
// Types shared by the variable latency I/O port controller.
// Assumes the defines header is on the include path.
`include "vlp_defines.svh"

package vlp_pkg;

    // Burst command: beats_m1 is the beat count minus one.
    typedef struct packed {
        logic                      write;
        logic                      dma_hold;
        logic [2:0]                cs;
        logic [7:0]                beats_m1;
        logic [`VLP_ADDR_W-1:0]    addr;
    } vlp_cmd_type;

    // One write beat: lane masks and data.
    typedef struct packed {
        logic [`VLP_LANES-1:0]     mask;
        logic [`VLP_DATA_W-1:0]    data;
    } vlp_wbeat_type;

    typedef enum logic [2:0] {
        VLP_IDLE, VLP_SETUP, VLP_STROBE, VLP_LATCH, VLP_HOLD, VLP_GAP, VLP_TAIL
    } vlp_state_type;

endpackage

/* File: rtl/vlp_buf.sv */
// Small FIFO with valid and ready on both sides.
// Assumes one clock, a synchronised active-low reset and a clock enable.
`include "vlp_defines.svh"

module vlp_buf
    import vlp_pkg::*;
#(
    parameter int WIDTH = `VLP_DATA_W,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             en_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;

    wire push = en_i && in_valid_i && in_ready_o;
    wire pop  = en_i && out_valid_o && out_ready_i;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign in_ready_o  = (count_ff != (PW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign out_data_o  = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            if (pop) rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            if (push && !pop) count_ff <= count_ff + (PW+1)'(1);
            else if (pop && !push) count_ff <= count_ff - (PW+1)'(1);
        end
    end

    AST_BUF_NO_OVERFLOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (count_ff == (PW+1)'(DEPTH)) |-> !(en_i && in_valid_i))
        else $error("Buffer written while full.");

endmodule // vlp_buf

/* File: rtl/vlp_port.sv */
// Variable latency I/O port: burst sequencer driving the static memory pins.
// Assumes a command source, a write-beat source and a read-data sink on core_clk_i,
// and a companion chip whose ready pin is asynchronous to it.
`include "vlp_defines.svh"

module vlp_port
    import vlp_pkg::*;
#(
    parameter int CNT_W = 4,
    parameter int BUF_DEPTH = 2
) (
    input  wire logic                             core_clk_i,
    input  wire logic                             rst_n_i,
    input  wire logic                             clk_en_i,
    input  wire logic                             cmd_valid_i,
    input  wire vlp_cmd_type                      cmd_i,
    output logic                                  cmd_ready_o,
    input  wire logic                             wbeat_valid_i,
    input  wire vlp_wbeat_type                    wbeat_i,
    output logic                                  wbeat_ready_o,
    output logic                                  rdata_valid_o,
    output logic [`VLP_DATA_W-1:0]                rdata_o,
    input  wire logic                             rdata_ready_i,
    input  wire logic [`VLP_NUM_CS-1:0][CNT_W-1:0] first_access_strobe_count_i,
    input  wire logic [`VLP_NUM_CS-1:0][CNT_W-1:0] inter_beat_gap_count_i,
    input  wire logic [`VLP_NUM_CS-1:0]           bus_width_32_i,
    input  wire logic                             ready_i,
    output logic [`VLP_NUM_CS-1:0]                static_chip_select_n_o,
    output logic [`VLP_ADDR_W-1:0]                memory_address_bus_o,
    output logic [`VLP_LANES-1:0]                 byte_mask_o,
    output logic                                  read_strobe_n_o,
    output logic                                  io_write_strobe_n_o,
    output logic                                  general_write_enable_n_o,
    output logic                                  transceiver_direction_o,
    input  wire logic [`VLP_DATA_W-1:0]           memory_data_bus_i,
    output logic [`VLP_DATA_W-1:0]                memory_data_bus_o,
    output logic                                  memory_data_bus_oe_o,
    output logic                                  busy_o
);
    localparam int CW = CNT_W + 1;

    // ************************************************************
    // Reset release and ready synchroniser
    // ************************************************************
    logic [1:0] rst_sync_ff;
    wire        rst_n = rst_sync_ff[1];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rst_sync_ff <= 2'h0;
        else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    logic ready_meta_ff;
    logic ready_sync_ff;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ready_meta_ff <= 1'b0;
            ready_sync_ff <= 1'b0;
        end else if (clk_en_i) begin
            ready_meta_ff <= ready_i;
            ready_sync_ff <= ready_meta_ff;
        end
    end

    // ************************************************************
    // State and datapath registers
    // ************************************************************
    vlp_state_type          state_ff;
    vlp_state_type          nxt_state;
    vlp_cmd_type            cmd_ff;
    logic [CW-1:0]          phase_cnt_ff;
    logic [CW-1:0]          strobe_cnt_ff;
    logic [1:0]             ok_cnt_ff;
    logic [7:0]             beats_left_ff;
    logic [`VLP_ADDR_W-1:0] addr_ff;
    logic [`VLP_LANES-1:0]  mask_ff;
    logic [`VLP_DATA_W-1:0] wdata_ff;
    logic [`VLP_NUM_CS-1:0] cs_n_ff;
    logic                   rd_strobe_n_ff;
    logic                   wr_strobe_n_ff;
    logic                   dir_ff;
    logic                   strobe_on_ff;
    logic                   buf_in_ready;

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic logic [CNT_W-1:0] region_cnt(
        input logic [`VLP_NUM_CS-1:0][CNT_W-1:0] cnts,
        input logic [2:0]                        cs);
        region_cnt = (cs < 3'(`VLP_NUM_CS)) ? cnts[cs] : '0;
    endfunction

    function automatic logic region_w32(input logic [`VLP_NUM_CS-1:0] w, input logic [2:0] cs);
        region_w32 = (cs < 3'(`VLP_NUM_CS)) ? w[cs] : 1'b1;
    endfunction

    function automatic logic [`VLP_NUM_CS-1:0] cs_decode_n(input logic [2:0] cs);
        cs_decode_n = ~(`VLP_NUM_CS'(1) << cs);
    endfunction

    function automatic logic [`VLP_LANES-1:0] lane_mask(input logic [`VLP_LANES-1:0] m,
                                                        input logic w32);
        lane_mask = w32 ? m : (m | `VLP_MASK_HI16);
    endfunction

    wire vlp_cmd_type cur_cmd = (state_ff == VLP_IDLE) ? cmd_i : cmd_ff;
    wire [CNT_W-1:0]  rdf_sel = region_cnt(first_access_strobe_count_i, cmd_ff.cs);
    wire [CNT_W-1:0]  rdn_sel = region_cnt(inter_beat_gap_count_i, cmd_ff.cs);
    wire              w32_cmd = region_w32(bus_width_32_i, cmd_ff.cs);
    wire              w32_new = region_w32(bus_width_32_i, cmd_i.cs);
    wire              is_wr = cmd_ff.write;
    wire              beat_go = is_wr ? wbeat_valid_i : buf_in_ready;
    wire              accept = clk_en_i && (state_ff == VLP_IDLE) && cmd_valid_i;
    wire              setup_done = (phase_cnt_ff >= CW'(`VLP_SETUP_LAST));
    wire              gap_done = (phase_cnt_ff >= {1'b0, rdn_sel});
    wire              last_beat = (beats_left_ff == `VLP_BEATS_RST);
    wire              min_met = (strobe_cnt_ff >= {1'b0, rdf_sel});
    wire              sample_en = (state_ff == VLP_STROBE) &&
                                  (strobe_cnt_ff >= CW'(`VLP_RDY_SAMPLE_CYC));
    wire              sample_ok = sample_en && ready_sync_ff;
    wire              third_ok = sample_ok && (ok_cnt_ff == `VLP_RDY_OK_LAST);
    wire              start_beat = beat_go &&
                                   (((state_ff == VLP_SETUP) && setup_done) ||
                                    ((state_ff == VLP_GAP) && gap_done));
    wire              buf_push = (state_ff == VLP_LATCH) && !is_wr;
    wire [`VLP_ADDR_W-1:0] addr_step = w32_cmd ? `VLP_STEP32 : `VLP_STEP16;
    wire [`VLP_DATA_W-1:0] rd_capture = w32_cmd ? memory_data_bus_i
                                                : (memory_data_bus_i & `VLP_LO16);
    wire [`VLP_LANES-1:0]  beat_mask = lane_mask(wbeat_i.mask, w32_cmd);

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            VLP_IDLE: begin
                if (cmd_valid_i) nxt_state = VLP_SETUP;
            end
            VLP_SETUP: begin
                if (start_beat) nxt_state = VLP_STROBE;
            end
            VLP_STROBE: begin
                if (third_ok) nxt_state = VLP_LATCH;
            end
            VLP_LATCH: begin
                nxt_state = VLP_HOLD;
            end
            VLP_HOLD: begin
                if (min_met) nxt_state = last_beat ? VLP_TAIL : VLP_GAP;
            end
            VLP_GAP: begin
                if (start_beat) nxt_state = VLP_STROBE;
            end
            VLP_TAIL: begin
                nxt_state = VLP_IDLE;
            end
        endcase
    end

    wire nxt_cs_on = (nxt_state != VLP_IDLE);
    wire nxt_strobe_on = (nxt_state == VLP_STROBE) || (nxt_state == VLP_LATCH) ||
                         (nxt_state == VLP_HOLD);
    wire [`VLP_LANES-1:0] nxt_mask = accept ? `VLP_MASK_NONE :
                                     (start_beat && is_wr) ? beat_mask :
                                     (nxt_state == VLP_IDLE) ? `VLP_MASK_NONE : mask_ff;
    wire nxt_wr_suppress = (nxt_mask == `VLP_MASK_ALL);

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff      <= VLP_IDLE;
            phase_cnt_ff  <= '0;
            strobe_cnt_ff <= '0;
            ok_cnt_ff     <= 2'h0;
            beats_left_ff <= `VLP_BEATS_RST;
        end else if (clk_en_i) begin
            state_ff <= nxt_state;
            if (accept || (state_ff == VLP_HOLD)) phase_cnt_ff <= '0;
            else if (phase_cnt_ff != '1) phase_cnt_ff <= phase_cnt_ff + CW'(1);
            if (start_beat) begin
                strobe_cnt_ff <= '0;
                ok_cnt_ff     <= 2'h0;
            end else begin
                if (strobe_cnt_ff != '1) strobe_cnt_ff <= strobe_cnt_ff + CW'(1);
                if (sample_ok && (ok_cnt_ff != 2'h3)) ok_cnt_ff <= ok_cnt_ff + 2'h1;
            end
            if (accept) beats_left_ff <= cmd_i.beats_m1;
            else if ((state_ff == VLP_HOLD) && min_met && !last_beat) begin
                beats_left_ff <= beats_left_ff - 8'h01;
            end
        end
    end

    // ************************************************************
    // Pin registers
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ff         <= '0;
            addr_ff        <= `VLP_ADDR_RST;
            wdata_ff       <= `VLP_DATA_RST;
            mask_ff        <= `VLP_MASK_NONE;
            cs_n_ff        <= `VLP_CS_IDLE;
            rd_strobe_n_ff <= 1'b1;
            wr_strobe_n_ff <= 1'b1;
            dir_ff         <= 1'b1;
            strobe_on_ff   <= 1'b0;
        end else if (clk_en_i) begin
            if (accept) begin
                cmd_ff  <= cmd_i;
                addr_ff <= cmd_i.addr;
            end else if ((state_ff == VLP_GAP) && (phase_cnt_ff == '0) && !cmd_ff.dma_hold) begin
                addr_ff <= addr_ff + addr_step;
            end
            if (start_beat && is_wr) wdata_ff <= wbeat_i.data;
            mask_ff        <= nxt_mask;
            cs_n_ff        <= nxt_cs_on ? cs_decode_n(cur_cmd.cs) : `VLP_CS_IDLE;
            strobe_on_ff   <= nxt_strobe_on;
            rd_strobe_n_ff <= !(nxt_strobe_on && !cur_cmd.write);
            wr_strobe_n_ff <= !(nxt_strobe_on && cur_cmd.write && !nxt_wr_suppress);
            dir_ff         <= !(nxt_cs_on && cur_cmd.write);
        end
    end

    // ************************************************************
    // Read data buffer
    // ************************************************************
    vlp_buf #(
        .WIDTH (`VLP_DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_rd_buf (
        .clk_i       (core_clk_i),
        .rst_n_i     (rst_n),
        .en_i        (clk_en_i),
        .in_valid_i  (buf_push),
        .in_data_i   (rd_capture),
        .in_ready_o  (buf_in_ready),
        .out_valid_o (rdata_valid_o),
        .out_data_o  (rdata_o),
        .out_ready_i (rdata_ready_i)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign cmd_ready_o              = clk_en_i && (state_ff == VLP_IDLE);
    assign wbeat_ready_o            = clk_en_i && start_beat && is_wr;
    assign static_chip_select_n_o   = cs_n_ff;
    assign memory_address_bus_o     = addr_ff;
    assign byte_mask_o              = mask_ff;
    assign read_strobe_n_o          = rd_strobe_n_ff;
    assign io_write_strobe_n_o      = wr_strobe_n_ff;
    assign general_write_enable_n_o = 1'b1;
    assign transceiver_direction_o  = dir_ff;
    assign memory_data_bus_o        = wdata_ff;
    assign memory_data_bus_oe_o     = !dir_ff;
    assign busy_o                   = (state_ff != VLP_IDLE);

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking vlp_cb @(posedge core_clk_i iff clk_en_i);
    endclocking
    default disable iff (!rst_n);

    wire cs_on = (cs_n_ff != `VLP_CS_IDLE);

    AST_STROBE_TWO_AFTER_CS: assert property (
        $rose(cs_on) ##1 beat_go |=> strobe_on_ff && $past(cs_on, 2))
        else $error("First strobe not two cycles after chip select.");
    AST_READ_STROBE_TOGGLES: assert property (
        (state_ff == VLP_HOLD) && min_met && !last_beat && !is_wr |=> read_strobe_n_o)
        else $error("Read strobe held across beats.");
    AST_GENERAL_WE_IDLE: assert property (
        general_write_enable_n_o && !(!read_strobe_n_o && !io_write_strobe_n_o))
        else $error("General write enable used or both strobes active.");
    AST_NO_EARLY_SAMPLE: assert property (
        $rose(strobe_on_ff) |-> (ok_cnt_ff == 2'h0) ##1 (ok_cnt_ff == 2'h0))
        else $error("Ready counted before second strobe cycle.");
    AST_MIN_STROBE: assert property (
        $fell(strobe_on_ff) |-> $past(strobe_cnt_ff) >= {1'b0, rdf_sel})
        else $error("Strobe shorter than first access count plus one.");
    AST_LATCH_AFTER_THIRD: assert property (
        third_ok |=> (state_ff == VLP_LATCH) && (buf_push == !is_wr) ##1
                     (state_ff == VLP_HOLD) && strobe_on_ff)
        else $error("Read data not latched after third ready sample.");
    AST_ADDR_AFTER_RELEASE: assert property (
        $fell(strobe_on_ff) |-> $stable(addr_ff))
        else $error("Address changed with strobe release.");
    AST_GAP_LENGTH: assert property (
        $rose(strobe_on_ff) && $past(state_ff == VLP_GAP) |-> $past(phase_cnt_ff) >= {1'b0, rdn_sel})
        else $error("Inter-beat gap too short.");
    AST_TAIL_HOLD: assert property (
        (state_ff == VLP_TAIL) |-> cs_on && !strobe_on_ff ##1 !cs_on && (byte_mask_o == `VLP_MASK_NONE))
        else $error("Select not held exactly one cycle after burst.");
    AST_DMA_HOLD: assert property (
        (state_ff != VLP_IDLE) && !accept && cmd_ff.dma_hold |=> $stable(addr_ff))
        else $error("Address moved in DMA hold mode.");
    AST_MASKED_WRITE: assert property (
        !io_write_strobe_n_o |-> byte_mask_o != `VLP_MASK_ALL)
        else $error("Write strobe with every lane masked.");
    AST_DIRECTION: assert property (
        (!io_write_strobe_n_o |-> !transceiver_direction_o) and
        (!read_strobe_n_o |-> transceiver_direction_o))
        else $error("Direction does not match data drive.");

endmodule // vlp_port

/* File: dv/vlp_companion.sv */
// Companion chip model: answers reads, records writes, inserts wait states.
// Assumes the port's pins on the same clock; wait_i sets the wait cycles.
module vlp_companion (
    input  wire logic        clk_i,
    input  wire logic [5:0]  cs_n_i,
    input  wire logic [25:0] addr_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [3:0]  mask_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [7:0]  wait_i,
    output logic             ready_o,
    output logic [31:0]      rdata_o,
    output logic [31:0]      wr_data_o,
    output logic [3:0]       wr_mask_o,
    output logic [25:0]      last_addr_o,
    output logic [7:0]       n_wr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // Beat tracking.
    // ********************
    logic [7:0]  cnt_ff = 8'h00;
    logic [31:0] last_ff = 32'h00000000;
    logic        act;
    logic [7:0]  nwr_ff = 8'h00;
    assign n_wr_o = nwr_ff;
    assign act = (cs_n_i != 6'h3F) && !(rd_n_i && wr_n_i);
    assign ready_o = (cnt_ff >= wait_i);
    assign rdata_o = !rd_n_i ? {addr_i[15:0], ~addr_i[15:0]} : ~last_ff;
    always @(negedge wr_n_i) nwr_ff <= nwr_ff + 8'h01;
    always @(posedge clk_i) begin
        cnt_ff <= !act ? 8'h00 : (cnt_ff < wait_i) ? cnt_ff + 8'h01 : cnt_ff;
        if (act) last_addr_o <= addr_i;
        if (!rd_n_i) last_ff <= rdata_o;
        if (!wr_n_i) wr_data_o <= wdata_i;
        if (!wr_n_i) wr_mask_o <= mask_i;
    end
endmodule // vlp_companion

/* File: dv/test_vlp_port.sv */
// Bench for the port: bursts through the command and beat streams.
// Assumes the package, defines header and companion model compile first.
`include "vlp_defines.svh"

module test_vlp_port
    import vlp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // Stimulus and monitor.
    // ********************
    logic          clk = 1'b0, rst_n = 1'b0, cv = 1'b0, wv = 1'b0, rr = 1'b1;
    logic          pstb = 1'b0, pact = 1'b0, ce = 1'b1;
    vlp_cmd_type   cmd = '0;
    vlp_wbeat_type wb = '0;
    vlp_wbeat_type wq[$];
    logic [31:0]   rq[$];
    logic [7:0]    wt = 8'h00, nwr, n0;
    logic [5:0]    cs;
    logic [25:0]   ad, pad, pad_q;
    logic [3:0]    bm, pwm;
    logic [31:0]   rd, mdi, mdo, pwd;
    logic          cr, wr, rv, rdy, dir, oe, rs, ws, we, busy, act, stb;
    int            n_fail = 0, n_compared = 0, since, first, lo, hi, lo_min, gap_min, tail, nstb;
    assign act = (cs !== 6'h3F);
    assign stb = !(rs && ws);
    vlp_port #(.CNT_W(4), .BUF_DEPTH(2)) dut_u (
        .core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(ce), .cmd_valid_i(cv), .cmd_i(cmd),
        .cmd_ready_o(cr), .wbeat_valid_i(wv), .wbeat_i(wb), .wbeat_ready_o(wr),
        .rdata_valid_o(rv), .rdata_o(rd), .rdata_ready_i(rr),
        .first_access_strobe_count_i(24'h000031), .inter_beat_gap_count_i(24'h000020),
        .bus_width_32_i(6'h3D), .ready_i(rdy), .static_chip_select_n_o(cs),
        .memory_address_bus_o(ad), .byte_mask_o(bm), .read_strobe_n_o(rs),
        .io_write_strobe_n_o(ws), .general_write_enable_n_o(we),
        .transceiver_direction_o(dir), .memory_data_bus_i(mdi), .memory_data_bus_o(mdo),
        .memory_data_bus_oe_o(oe), .busy_o(busy));
    vlp_companion peer_u (.clk_i(clk), .cs_n_i(cs), .addr_i(ad), .rd_n_i(rs), .wr_n_i(ws),
        .mask_i(bm), .wdata_i(mdo), .wait_i(wt), .ready_o(rdy), .rdata_o(mdi),
        .wr_data_o(pwd), .wr_mask_o(pwm), .last_addr_o(pad), .n_wr_o(nwr));
    initial forever #50 clk = ~clk;

    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    function automatic logic [31:0] pat(input logic [25:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction

    task automatic run(input logic w, input logic d, input logic [2:0] c,
                       input logic [7:0] n, input logic [25:0] a);
        cmd = '{w, d, c, n, a};
        cv = 1'b1;
        for (int k = 0; k < 99 && cr !== 1'b1; k++) @(posedge clk) #10;
        @(posedge clk);
        #10 cv = 1'b0;
        for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk) #10;
        ck(busy, 1'b0, "done");
        repeat (4) @(posedge clk);
        #10;
    endtask

    always @(posedge clk) begin
        if (wr === 1'b1 && wv) void'(wq.pop_front());
        if (rv === 1'b1 && rr && ce) rq.push_back(rd);
        #10 wv = (wq.size() != 0);
        if (wv) wb = wq[0];
    end

    always @(posedge clk) if (rst_n) begin
        ck({we, oe, dir}, {1'b1, act && cmd.write, !(act && cmd.write)}, "pins");
        if (stb && pstb) ck(ad, pad_q, "addr");
        if (!act && pact) tail = hi;
        if (act && !pact) begin
            since = 0;
            nstb = 0;
            lo_min = 99;
            gap_min = 99;
        end
        if (stb && !pstb) begin
            if (nstb == 0) first = since;
            else if (hi < gap_min) gap_min = hi;
            nstb++;
            lo = 0;
        end
        if (!stb && pstb && lo < lo_min) lo_min = lo;
        if (stb) lo++;
        hi = stb ? 0 : hi + 1;
        since++;
        pstb = stb;
        pact = act;
        pad_q = ad;
    end

    initial begin
        repeat (2) @(posedge clk);
        #10 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #10 ck({cs, rs, ws, bm, dir}, {6'h3F, 2'h3, 4'h0, 1'b1}, "idle");
        run(1'b0, 1'b0, 3'h0, 8'h02, 26'h0000100);
        ck(first, 2, "setup");
        ck(lo_min, 6, "width");
        ck(gap_min, 1, "gap");
        ck(tail, 1, "tail");
        ck(nstb, 3, "beats");
        ck(pad, 26'h0000108, "step");
        for (int k = 0; k < 3; k++) ck(rq.pop_front(), pat(26'h100 + 26'(4 * k)), "rd");
        wq = '{'{4'h0, 32'h11223344}, '{4'hF, 32'h55667788}, '{4'h3, 32'h99AABBCC}};
        n0 = nwr;
        run(1'b1, 1'b0, 3'h0, 8'h02, 26'h3FFFFF0);
        ck(nwr - n0, 2, "wr count");
        ck(pwd, 32'h99AABBCC, "wd");
        ck(pwm, 4'h3, "mask");
        ck(pad, 26'h3FFFFF8, "wa");
        rr = 1'b0;
        wt = 8'h0C;
        fork
            run(1'b0, 1'b1, 3'h1, 8'h03, 26'h2000001);
            begin
                repeat (60) @(posedge clk);
                #10 ck({busy, rv}, 2'h3, "stall");
                ce = 1'b0;
                rr = 1'b1;
                repeat (4) @(posedge clk);
                #10 ck({cs, rs, cr, busy, rv}, {6'h3D, 1'b1, 1'b0, 1'b1, 1'b1}, "freeze");
                ck(ad, 26'h2000001, "freeze addr");
                ce = 1'b1;
            end
        join
        ck(gap_min, 3, "gap1");
        ck(lo_min > 12, 1, "wait");
        ck(pad, 26'h2000001, "hold");
        for (int k = 0; k < 4; k++) ck(rq.pop_front(), pat(26'h2000001) & `VLP_LO16, "r16");
        wt = 8'h00;
        wq = '{'{4'h0, 32'hDEADBEEF}};
        run(1'b1, 1'b0, 3'h1, 8'h00, 26'h0000040);
        ck(pwm, 4'hC, "m16");
        ck(pwd[15:0], 16'hBEEF, "w16");
        end_of_test();
    end

    initial begin
        #(5000 * 100);
        n_fail++;
        $display("[FAIL] %0t watchdog", $time);
        end_of_test();
    end
endmodule // test_vlp_port
